// ==== rtl/cpucfg_ctrl.sv ====
`timescale 1ns/1ps
module cpucfg_ctrl #(
  parameter bit FPU_PRESENT = 1'b1
) (
  input  wire logic                        mclk,
  input  wire logic                        sys_rst,
  input  wire logic                        clk_en,
  input  wire logic                        cop_wr,
  input  wire logic                        cop_rd,
  input  wire logic [4:0]                  cop_sel,
  input  wire logic [31:0]                 cop_wdata,
  output logic      [31:0]                 cop_rdata,
  input  wire logic [cpucfg_pkg::IRQ_COUNT-1:0] ext_irq_n,
  input  wire logic                        fpu_irq_req,
  output logic      [cpucfg_pkg::IRQ_COUNT-1:0] core_irq,
  output logic                             core_stall,
  output logic                             core_tick,
  output logic                             system_clock_out,
  input  wire logic                        bus_turn_req,
  output logic                             bus_turn_ok,
  output logic                             data_block_fill_size,
  input  wire logic                        cache_idle,
  output cpucfg_pkg::cpucfg_cache_s        cache_cfg,
  input  wire logic                        dc_wr_req,
  input  wire logic                        dc_miss_req,
  output logic                             mem_wr_req,
  output logic                             mem_miss_req,
  input  wire logic                        load_done,
  input  wire logic                        load_miss,
  input  wire logic                        fpu_instr_valid,
  output logic                             fpu_issue,
  output logic                             fpu_trap,
  input  wire logic                        fpu_compare_result,
  input  wire logic                        ext_cond_in,
  output logic                             fpu_condition_flag
);

  localparam int NI = cpucfg_pkg::IRQ_COUNT;
  localparam logic [1:0] TURN_BASE = 2'(cpucfg_pkg::TURN_BASE_CYC);
  localparam logic [1:0] TURN_EXT  = 2'(cpucfg_pkg::TURN_EXT_CYC);

  cpucfg_pkg::cpucfg_cfg_s   cfg_r;
  cpucfg_pkg::cpucfg_cfg_s   cfg_nxt;
  cpucfg_pkg::cpucfg_stat_s  stat_r;
  cpucfg_pkg::cpucfg_stat_s  stat_nxt;
  cpucfg_pkg::cpucfg_cache_s cache_r;
  cpucfg_pkg::cpucfg_cache_s cache_nxt;
  logic [31:0]               rdata_r;
  logic [31:0]               rdata_nxt;
  logic [1:0]                turn_r;
  logic [1:0]                turn_nxt;
  logic [NI-1:0]             irq_r;
  logic [NI-1:0]             irq_nxt;
  logic [NI-1:0]             irq_meta_r;
  logic [NI-1:0]             irq_sync_r;
  logic                      cond_meta_r;
  logic                      cond_sync_r;
  logic                      cond_r;
  logic                      cond_nxt;
  logic                      cfg_wr;
  logic                      stat_wr;
  logic                      irq_any;
  logic [NI-1:0]             fpu_irq_mask;
  logic [31:0]               cfg_word;
  logic [31:0]               stat_word;

  assign cfg_wr  = cop_wr && (cop_sel == cpucfg_pkg::CFG_SEL);
  assign stat_wr = cop_wr && (cop_sel == cpucfg_pkg::STAT_SEL);

  // Pin synchronisers; first stage feeds nothing but the second
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      irq_meta_r  <= '0;
      irq_sync_r  <= '0;
      cond_meta_r <= 1'b0;
      cond_sync_r <= 1'b0;
    end else if (clk_en) begin
      irq_meta_r  <= ~ext_irq_n;
      irq_sync_r  <= irq_meta_r;
      cond_meta_r <= ext_cond_in;
      cond_sync_r <= cond_meta_r;
    end
  end

  // One-hot pin mask from the select field; 6 and 7 select no pin
  always_comb begin
    fpu_irq_mask = '0;
    if (cfg_r.fpu_irq < 3'(NI)) begin
      fpu_irq_mask[cfg_r.fpu_irq] = 1'b1;
    end
  end

  // Interrupt routing: the float request replaces its chosen pin
  for (genvar i = 0; i < NI; i++) begin : g_irq
    always_comb begin
      if (fpu_irq_mask[i]) begin
        irq_nxt[i] = fpu_irq_req;
      end else begin
        irq_nxt[i] = irq_sync_r[i];
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      irq_r <= '0;
    end else if (clk_en) begin
      irq_r <= irq_nxt;
    end
  end

  assign core_irq = irq_r;
  assign irq_any  = |irq_nxt;

  // Configuration register
  always_comb begin
    cfg_nxt = cfg_r;
    if (cfg_wr && !cfg_r.lock) begin
      cfg_nxt = cop_wdata[cpucfg_pkg::CFG_LOCK_BIT:cpucfg_pkg::CFG_FIELD_LSB];
    end
    // Wake on any interrupt; a write that sets halt while one is pending is lost
    if (cfg_nxt.halt && irq_any) begin
      cfg_nxt.halt = 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      cfg_r <= cpucfg_pkg::CFG_RST;
    end else if (clk_en) begin
      cfg_r <= cfg_nxt;
    end
  end

  assign core_stall           = cfg_r.halt;
  assign data_block_fill_size = cfg_r.fill_four;

  // Status bits owned here; the miss flag is not software-writable
  always_comb begin
    stat_nxt = stat_r;
    if (stat_wr) begin
      stat_nxt.cu1 = cop_wdata[cpucfg_pkg::STAT_CU1_BIT];
      stat_nxt.swc = cop_wdata[cpucfg_pkg::STAT_SWC_BIT];
      stat_nxt.isc = cop_wdata[cpucfg_pkg::STAT_ISC_BIT];
    end
    if (load_done && stat_r.isc) begin
      stat_nxt.cm = load_miss;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      stat_r <= cpucfg_pkg::STAT_RST;
    end else if (clk_en) begin
      stat_r <= stat_nxt;
    end
  end

  // Isolation blocks the memory side, not the cache itself
  assign mem_wr_req   = dc_wr_req && !stat_r.isc;
  assign mem_miss_req = dc_miss_req && !stat_r.isc;

  // Coprocessor 1 gating
  assign fpu_issue = fpu_instr_valid && stat_r.cu1;
  assign fpu_trap  = fpu_instr_valid && !stat_r.cu1;

  // Cache sizes only change while no access is in flight; the swap bit follows swc every cycle
  always_comb begin
    cache_nxt = cache_r;
    cache_nxt.dside_uses_icache = stat_r.swc;
    if (cache_idle) begin
      if (cfg_r.split) begin
        cache_nxt.icache_kb = cpucfg_pkg::CACHE_KB_SPLIT;
        cache_nxt.dcache_kb = cpucfg_pkg::CACHE_KB_SPLIT;
      end else begin
        cache_nxt.icache_kb = cpucfg_pkg::ICACHE_KB_DEF;
        cache_nxt.dcache_kb = cpucfg_pkg::DCACHE_KB_DEF;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      cache_r <= {cpucfg_pkg::ICACHE_KB_DEF, cpucfg_pkg::DCACHE_KB_DEF, 1'b0};
    end else if (clk_en) begin
      cache_r <= cache_nxt;
    end
  end

  assign cache_cfg = cache_r;

  // Bus turnaround gap after each mastership change
  always_comb begin
    turn_nxt = turn_r;
    if (bus_turn_req) begin
      turn_nxt = cfg_r.turn_ext ? TURN_EXT : TURN_BASE;
    end else if (turn_r != 2'h0) begin
      turn_nxt = turn_r - 2'h1;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      turn_r <= 2'h0;
    end else if (clk_en) begin
      turn_r <= turn_nxt;
    end
  end

  assign bus_turn_ok = (turn_r == 2'h0) && !bus_turn_req;

  // Condition flag: external pin only counts without an on-chip unit
  always_comb begin
    if (FPU_PRESENT) begin
      cond_nxt = fpu_compare_result;
    end else begin
      cond_nxt = cond_sync_r;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      cond_r <= 1'b0;
    end else if (clk_en) begin
      cond_r <= cond_nxt;
    end
  end

  assign fpu_condition_flag = cond_r;

  // Read images; unimplemented bits stay zero
  always_comb begin
    cfg_word = 32'h0000_0000;
    cfg_word[cpucfg_pkg::CFG_LOCK_BIT:cpucfg_pkg::CFG_FIELD_LSB] = cfg_r;
  end

  always_comb begin
    stat_word                           = 32'h0000_0000;
    stat_word[cpucfg_pkg::STAT_CU1_BIT] = stat_r.cu1;
    stat_word[cpucfg_pkg::STAT_CM_BIT]  = stat_r.cm;
    stat_word[cpucfg_pkg::STAT_SWC_BIT] = stat_r.swc;
    stat_word[cpucfg_pkg::STAT_ISC_BIT] = stat_r.isc;
  end

  // Read port; unknown selects read zero
  always_comb begin
    rdata_nxt = rdata_r;
    if (cop_rd) begin
      case (cop_sel)
        cpucfg_pkg::CFG_SEL: begin
          rdata_nxt = cfg_word;
        end
        cpucfg_pkg::STAT_SEL: begin
          rdata_nxt = stat_word;
        end
        default: begin
          rdata_nxt = 32'h0000_0000;
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rdata_r <= 32'h0000_0000;
    end else if (clk_en) begin
      rdata_r <= rdata_nxt;
    end
  end

  assign cop_rdata = rdata_r;

  // Core pacing and the outgoing system clock share one divider
  cpucfg_clkdiv #(
    .DIV        (cpucfg_pkg::RF_DIV)
  ) u_div (
    .mclk       (mclk),
    .sys_rst    (sys_rst),
    .clk_en     (clk_en),
    .slow       (cfg_r.rf),
    .tick       (core_tick),
    .system_clock_out_out (system_clock_out)
  );

endmodule : cpucfg_ctrl

// ==== rtl/cpucfg_pkg.sv ====
package cpucfg_pkg;

  // Coprocessor register numbers reached by the move instructions
  localparam logic [4:0] CFG_SEL        = 5'h03;
  localparam logic [4:0] STAT_SEL       = 5'h0C;

  // Configuration register layout
  localparam int         CFG_FIELD_LSB  = 23;
  localparam int         CFG_FIELD_W    = 9;
  localparam int         CFG_LOCK_BIT   = 31;
  localparam int         CFG_TURN_BIT   = 30;
  localparam int         CFG_FILL_BIT   = 29;
  localparam int         CFG_FPIRQ_MSB  = 28;
  localparam int         CFG_FPIRQ_LSB  = 26;
  localparam int         CFG_HALT_BIT   = 25;
  localparam int         CFG_RF_BIT     = 24;
  localparam int         CFG_SPLIT_BIT  = 23;

  // Status register bits kept by this block
  localparam int         STAT_CU1_BIT   = 29;
  localparam int         STAT_CM_BIT    = 19;
  localparam int         STAT_SWC_BIT   = 17;
  localparam int         STAT_ISC_BIT   = 16;

  // Reset values: float exceptions on interrupt input 3
  localparam logic [8:0] CFG_RST        = 9'h018;
  localparam logic [3:0] STAT_RST       = 4'h0;

  // Interrupt inputs of the core
  localparam int         IRQ_COUNT      = 6;

  // Clocking
  localparam int         CLK_NS         = 10;
  localparam int         RF_DIV         = 16;
  localparam int         TURN_BASE_NS   = 10;
  localparam int         TURN_EXT_NS    = 30;
  localparam int         TURN_BASE_CYC  = (TURN_BASE_NS + CLK_NS - 1) / CLK_NS;
  localparam int         TURN_EXT_CYC   = (TURN_EXT_NS + CLK_NS - 1) / CLK_NS;

  // Cache sizes in kB
  localparam logic [4:0] ICACHE_KB_DEF  = 5'h10;
  localparam logic [4:0] DCACHE_KB_DEF  = 5'h04;
  localparam logic [4:0] CACHE_KB_SPLIT = 5'h08;

  typedef struct packed {
    logic       lock;
    logic       turn_ext;
    logic       fill_four;
    logic [2:0] fpu_irq;
    logic       halt;
    logic       rf;
    logic       split;
  } cpucfg_cfg_s;

  typedef struct packed {
    logic cu1;
    logic cm;
    logic swc;
    logic isc;
  } cpucfg_stat_s;

  typedef struct packed {
    logic [4:0] icache_kb;
    logic [4:0] dcache_kb;
    logic       dside_uses_icache;
  } cpucfg_cache_s;

endpackage : cpucfg_pkg

// ==== rtl/cpucfg_clkdiv.sv ====
`timescale 1ns/1ps
module cpucfg_clkdiv #(
  parameter int DIV = 16
) (
  input  wire logic mclk,
  input  wire logic sys_rst,
  input  wire logic clk_en,
  input  wire logic slow,
  output logic      tick,
  output logic      system_clock_out_out
);

  localparam int CW = $clog2(DIV);
  localparam logic [CW-1:0] LIMIT = CW'(DIV - 1);

  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;
  logic          clk_r;
  logic          clk_nxt;
  logic          tick_int;

  // Full rate ticks every cycle; reduced rate once per DIV
  assign tick_int = !slow || (cnt_r == LIMIT);
  assign tick     = tick_int;

  always_comb begin
    cnt_nxt = cnt_r;
    clk_nxt = clk_r;
    if (tick_int) begin
      cnt_nxt = '0;
      clk_nxt = !clk_r;
    end else begin
      cnt_nxt = cnt_r + CW'(1);
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      cnt_r <= '0;
      clk_r <= 1'b0;
    end else if (clk_en) begin
      cnt_r <= cnt_nxt;
      clk_r <= clk_nxt;
    end
  end

  assign system_clock_out_out = clk_r;

endmodule : cpucfg_clkdiv

// ==== dv/cpucfg_ctrl_sva.sv ====
`timescale 1ns/1ps
module cpucfg_ctrl_chk #(
  parameter bit FPU_PRESENT = 1'b1
) (
  input wire logic                                mclk,
  input wire logic                                sys_rst,
  input wire logic                                clk_en,
  input wire logic                                cop_rd,
  input wire logic [4:0]                          cop_sel,
  input wire logic [31:0]                         cop_rdata,
  input wire logic [cpucfg_pkg::IRQ_COUNT-1:0]    core_irq,
  input wire logic                                core_stall,
  input wire logic                                core_tick,
  input wire logic                                system_clock_out,
  input wire logic                                bus_turn_req,
  input wire logic                                bus_turn_ok,
  input wire logic                                dc_wr_req,
  input wire logic                                dc_miss_req,
  input wire logic                                mem_wr_req,
  input wire logic                                mem_miss_req,
  input wire logic                                fpu_instr_valid,
  input wire logic                                fpu_issue,
  input wire logic                                fpu_trap,
  input wire logic                                fpu_compare_result,
  input wire logic                                fpu_condition_flag
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  // Gap is at least the request cycle plus one
  sequence s_gap;
    !bus_turn_ok ##1 !bus_turn_ok;
  endsequence
  sequence s_cfg_rd;
    cop_rd && clk_en && cop_sel == cpucfg_pkg::CFG_SEL;
  endsequence
  property p_turn;
    bus_turn_req && clk_en |-> s_gap;
  endproperty
  property p_rsvd;
    s_cfg_rd |=> cop_rdata[22:0] == 23'h000000;
  endproperty
  property p_hold;
    !($past(cop_rd) && $past(clk_en)) |-> $stable(cop_rdata);
  endproperty
  property p_iso_wr;
    mem_wr_req |-> dc_wr_req;
  endproperty
  property p_iso_miss;
    mem_miss_req |-> dc_miss_req;
  endproperty
  property p_trap;
    fpu_trap |-> fpu_instr_valid && !fpu_issue;
  endproperty
  property p_cond;
    !sys_rst && FPU_PRESENT && clk_en |=> fpu_condition_flag == $past(fpu_compare_result);
  endproperty
  property p_stall;
    |core_irq |-> !core_stall;
  endproperty
  property p_system_clock_out;
    $changed(system_clock_out) |-> $past(core_tick);
  endproperty
  a_turn: assert property (p_turn) else $error("Turnaround gap too short");
  a_rsvd: assert property (p_rsvd) else $error("Reserved bits not zero");
  a_hold: assert property (p_hold) else $error("Read data moved");
  a_iso_wr: assert property (p_iso_wr) else $error("Stray memory write");
  a_iso_miss: assert property (p_iso_miss) else $error("Stray miss request");
  a_trap: assert property (p_trap) else $error("Bad trap");
  a_cond: assert property (p_cond) else $error("Flag not from compare");
  a_stall: assert property (p_stall) else $error("Stall held on interrupt");
  a_system_clock_out: assert property (p_system_clock_out) else $error("Clock out off tick");
endmodule : cpucfg_ctrl_chk

bind cpucfg_ctrl cpucfg_ctrl_chk #(.FPU_PRESENT(FPU_PRESENT)) u_chk (
  .mclk, .sys_rst, .clk_en, .cop_rd, .cop_sel, .cop_rdata, .core_irq, .core_stall,
  .core_tick, .system_clock_out, .bus_turn_req, .bus_turn_ok, .dc_wr_req, .dc_miss_req,
  .mem_wr_req, .mem_miss_req, .fpu_instr_valid, .fpu_issue, .fpu_trap,
  .fpu_compare_result, .fpu_condition_flag
);

// ==== dv/testbench.sv ====
`timescale 1ns/1ps
module testbench;
  localparam logic [4:0]  CS    = cpucfg_pkg::CFG_SEL;
  localparam logic [4:0]  SS    = cpucfg_pkg::STAT_SEL;
  localparam logic [31:0] CDEF  = {cpucfg_pkg::CFG_RST, 23'h000000};
  localparam logic [10:0] KDEF  = {cpucfg_pkg::ICACHE_KB_DEF, cpucfg_pkg::DCACHE_KB_DEF, 1'b0};
  localparam logic [10:0] KSPL  = {cpucfg_pkg::CACHE_KB_SPLIT, cpucfg_pkg::CACHE_KB_SPLIT, 1'b0};
  logic        mclk = 1'b0, sys_rst = 1'b1, clk_en = 1'b1, cop_wr = 1'b0, cop_rd = 1'b0;
  logic [4:0]  cop_sel = 5'h00;
  logic [31:0] cop_wdata = 32'h00000000, cop_rdata, rv;
  logic [5:0]  ext_irq_n = 6'h3F, core_irq;
  logic        fpu_irq_req = 1'b0, core_stall, core_tick, system_clock_out;
  logic        bus_turn_req = 1'b0, bus_turn_ok, data_block_fill_size, cache_idle = 1'b1;
  logic        dc_wr_req = 1'b0, dc_miss_req = 1'b0, mem_wr_req, mem_miss_req;
  logic        load_done = 1'b0, load_miss = 1'b0, fpu_instr_valid = 1'b0;
  logic        fpu_issue, fpu_trap, fpu_compare_result = 1'b1, fpu_condition_flag;
  logic        ext_cond_in = 1'b1;
  cpucfg_pkg::cpucfg_cache_s cache_cfg;
  int          err_total = 0;
  int          checks_done = 0;
  int          t, s, n;
  cpucfg_ctrl dut (
    .mclk, .sys_rst, .clk_en, .cop_wr, .cop_rd, .cop_sel, .cop_wdata, .cop_rdata,
    .ext_irq_n, .fpu_irq_req, .core_irq, .core_stall, .core_tick, .system_clock_out,
    .bus_turn_req, .bus_turn_ok, .data_block_fill_size, .cache_idle, .cache_cfg,
    .dc_wr_req, .dc_miss_req, .mem_wr_req, .mem_miss_req, .load_done, .load_miss,
    .fpu_instr_valid, .fpu_issue, .fpu_trap, .fpu_compare_result, .ext_cond_in,
    .fpu_condition_flag
  );
  initial begin
    forever #5 mclk = ~mclk;
  end
  task results;
    if (err_total == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : results
  task chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk
  task cyc(input int k);
    repeat (k) @(posedge mclk);
    #1;
  endtask : cyc
  task wr(input logic [4:0] sel, input logic [31:0] d);
    @(posedge mclk);
    cop_wr <= 1'b1;
    cop_sel <= sel;
    cop_wdata <= d;
    @(posedge mclk);
    cop_wr <= 1'b0;
    #1;
  endtask : wr
  task rchk(input logic [4:0] sel, input logic [31:0] exp);
    @(posedge mclk);
    cop_rd <= 1'b1;
    cop_sel <= sel;
    @(posedge mclk);
    cop_rd <= 1'b0;
    #1;
    chk(cop_rdata, exp, "register read");
  endtask : rchk
  // Gap length counted from the edge that takes the request
  task turn(input int gap);
    @(posedge mclk);
    bus_turn_req <= 1'b1;
    #1 chk(bus_turn_ok, 1'b0, "turn in req cycle");
    @(posedge mclk);
    bus_turn_req <= 1'b0;
    repeat (gap) begin
      #1 chk(bus_turn_ok, 1'b0, "turn gap");
      @(posedge mclk);
    end
    #1 chk(bus_turn_ok, 1'b1, "turn end");
  endtask : turn
  task count(input int k);
    t = 0;
    s = 0;
    repeat (k) begin
      rv[0] = system_clock_out;
      cyc(1);
      t += int'(core_tick);
      s += int'(system_clock_out !== rv[0]);
    end
  endtask : count
  task t_reset;
    rchk(CS, CDEF);
    rchk(SS, 32'h00000000);
    chk(cache_cfg, KDEF, "cache default");
  endtask : t_reset
  task t_cfg;
    @(posedge mclk);
    cache_idle <= 1'b0;
    wr(CS, 32'h6C800000);
    cyc(3);
    chk(cache_cfg, KDEF, "split while busy");
    @(posedge mclk);
    cache_idle <= 1'b1;
    cyc(2);
    chk(cache_cfg, KSPL, "split");
    rchk(CS, 32'h6C800000);
    chk(data_block_fill_size, 1'b1, "fill four");
    turn(cpucfg_pkg::TURN_EXT_CYC);
    wr(CS, CDEF);
    cyc(2);
    chk(data_block_fill_size, 1'b0, "fill one");
    chk(cache_cfg, KDEF, "unsplit");
    turn(cpucfg_pkg::TURN_BASE_CYC);
  endtask : t_cfg
  task t_irq;
    for (int i = 0; i < 6; i++) begin
      wr(CS, {3'h0, 3'(i), 3'h0, 23'h000000});
      @(posedge mclk);
      fpu_irq_req <= 1'b1;
      cyc(2);
      chk(core_irq, 6'h01 << i, "float irq route");
      @(posedge mclk);
      fpu_irq_req <= 1'b0;
      cyc(2);
    end
    wr(CS, CDEF);
    @(posedge mclk);
    ext_irq_n <= 6'h35;
    cyc(5);
    chk(core_irq, 6'h02, "float pin ignored");
    @(posedge mclk);
    ext_irq_n <= 6'h3F;
    cyc(5);
  endtask : t_irq
  task t_halt;
    wr(CS, CDEF | 32'h02000000);
    cyc(1);
    chk(core_stall, 1'b1, "halt");
    @(posedge mclk);
    ext_irq_n <= 6'h3B;
    for (n = 0; n < 20 && core_stall !== 1'b0; n++) cyc(1);
    if (n == 20) begin
      err_total++;
      $display("CHECK FAILED %0t stall never released", $time);
      results();
    end
    chk(core_irq, 6'h04, "wake irq");
    @(posedge mclk);
    ext_irq_n <= 6'h3F;
    wr(CS, CDEF);
    cyc(5);
  endtask : t_halt
  task t_rf;
    wr(CS, CDEF | 32'h01000000);
    cyc(2);
    count(64);
    chk(t, 64 / cpucfg_pkg::RF_DIV, "slow ticks");
    chk(s, 64 / cpucfg_pkg::RF_DIV, "slow clock out");
    wr(CS, CDEF);
    cyc(2);
    count(32);
    chk(t, 32, "full ticks");
  endtask : t_rf
  task t_iso;
    wr(SS, 32'h00010000);
    @(posedge mclk);
    {dc_wr_req, dc_miss_req, load_done, load_miss} <= 4'hF;
    @(posedge mclk);
    load_done <= 1'b0;
    #1 chk({mem_wr_req, mem_miss_req}, 2'h0, "isolated");
    rchk(SS, 32'h00090000);
    @(posedge mclk);
    {load_done, load_miss} <= 2'h2;
    @(posedge mclk);
    load_done <= 1'b0;
    rchk(SS, 32'h00010000);
    wr(SS, 32'h00020000);
    cyc(2);
    chk({mem_wr_req, mem_miss_req}, 2'h3, "not isolated");
    chk(cache_cfg.dside_uses_icache, 1'b1, "swap");
    @(posedge mclk);
    {dc_wr_req, dc_miss_req} <= 2'h0;
    wr(SS, 32'h00000000);
  endtask : t_iso
  task t_fpu;
    @(posedge mclk);
    {fpu_instr_valid, fpu_compare_result} <= 2'h2;
    #1 chk({fpu_issue, fpu_trap}, 2'h1, "trap");
    wr(SS, 32'h20000000);
    chk({fpu_issue, fpu_trap}, 2'h2, "issue");
    chk(fpu_condition_flag, 1'b0, "compare low");
    @(posedge mclk);
    {fpu_instr_valid, fpu_compare_result} <= 2'h1;
    cyc(2);
    chk(fpu_condition_flag, 1'b1, "compare high");
  endtask : t_fpu
  task t_lock;
    wr(CS, 32'h8C000000);
    wr(CS, 32'h0D800000);
    rchk(CS, 32'h8C000000);
    chk(cache_cfg, KDEF, "locked split");
    @(posedge mclk);
    sys_rst <= 1'b1;
    repeat (3) @(posedge mclk);
    sys_rst <= 1'b0;
    rchk(CS, CDEF);
    wr(CS, 32'h0C800000);
    rchk(CS, 32'h0C800000);
  endtask : t_lock
  initial begin
    repeat (3) @(posedge mclk);
    sys_rst <= 1'b0;
    t_reset();
    t_cfg();
    t_irq();
    t_halt();
    t_rf();
    t_iso();
    t_fpu();
    t_lock();
    results();
  end
endmodule : testbench
